// [asc_pkg.sv]
// Shared constants for the sequencer control block.
package asc_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NSEQ = 4;
  localparam int RES_W = 10;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_ACTIVATION = 12'h000;
  localparam logic [11:0] OFS_RAW_IRQ = 12'h004;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
  localparam logic [11:0] OFS_MASKED_CLR = 12'h00C;
  localparam logic [11:0] OFS_OVERFLOW = 12'h010;
  localparam logic [11:0] OFS_TRIG_SEL = 12'h014;
  localparam logic [11:0] OFS_UNDERFLOW = 12'h018;
  localparam logic [11:0] OFS_PRIORITY = 12'h020;
  localparam logic [11:0] OFS_INITIATE = 12'h028;
  localparam logic [11:0] OFS_AVERAGING = 12'h030;
  localparam logic [11:0] OFS_SEQ_BASE = 12'h040;
  localparam logic [11:0] OFS_SEQ_END = 12'h0C0;
  localparam logic [11:0] OFS_LOOPBACK = 12'h100;
  // Offsets inside one sequencer's 0x20-byte window.
  localparam logic [4:0] REL_INPUT_SEL = 5'h00;
  localparam logic [4:0] REL_STEP_CTL = 5'h04;
  localparam logic [4:0] REL_FIFO_PORT = 5'h08;
  localparam logic [4:0] REL_FIFO_STAT = 5'h0C;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int CTL_DIFF = 0;
  localparam int CTL_END = 1;
  localparam int CTL_IE = 2;
  localparam int CTL_TEMP = 3;
  localparam int STAT_TAIL_LSB = 0;
  localparam int STAT_HEAD_LSB = 4;
  localparam int STAT_EMPTY = 8;
  localparam int STAT_FULL = 12;
  localparam logic [15:0] PRIORITY_RESET = 16'h3210;
  localparam logic [31:0] CTL_SEQ3_RESET = 32'h00000002;
  localparam logic [3:0] TRIG_PROCESSOR = 4'h0;
  localparam logic [3:0] TRIG_ALWAYS = 4'hF;
  localparam int N_PERIPH = 4;
  localparam logic [2:0] AVG_MAX_LOG = 3'h6;

  // ----------------------------------------
  // Converter clock divider
  // ----------------------------------------
  localparam longint CLK_HZ = 100_000_000;
  localparam longint CONV_TARGET_HZ = 16_667_000;
  localparam int CONV_DIV = int'((CLK_HZ + CONV_TARGET_HZ / 2) / CONV_TARGET_HZ);
  localparam logic [3:0] CONV_HALF = 4'(CONV_DIV / 2);

  // Steps and FIFO depth per sequencer (the two are equal).
  function automatic logic [3:0] asc_depth(input int k);
    asc_depth = (k == 0) ? 4'h8 : ((k == 3) ? 4'h1 : 4'h4);
  endfunction

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} asc_state_t;

endpackage

// [asc_result_fifo.sv]
// Circular buffer for one sequencer's results.
`timescale 1ns/1ps
module asc_result_fifo
  import asc_pkg::*;
#(
  parameter logic [3:0] DEPTH = 4'h8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [RES_W-1:0] push_data,
  input wire logic pop,
  output logic [RES_W-1:0] head_data,
  output logic [PTR_W-1:0] head,
  output logic [PTR_W-1:0] tail,
  output logic full,
  output logic empty
);

  logic [RES_W-1:0] mem [0:7];
  logic [CNT_W-1:0] count;
  logic do_push;
  logic do_pop;

  // A push into a full buffer and a pop of an empty one are dropped.
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign full = (count == DEPTH);
  assign empty = (count == 4'h0);
  assign head_data = mem[head];

  function automatic logic [PTR_W-1:0] wrap(input logic [PTR_W-1:0] p);
    wrap = (4'({1'b0, p}) == DEPTH - 4'h1) ? 3'h0 : p + 3'h1;
  endfunction

  // Storage has no reset; only entries under the pointers are read.
  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem[tail] <= push_data;
    end
  end

  // Pointers walk round the ring; the count tells full from empty.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      head <= 3'h0;
      tail <= 3'h0;
      count <= 4'h0;
    end
    else
    begin
      if (do_push)
      begin
        tail <= wrap(tail);
      end
      if (do_pop)
      begin
        head <= wrap(head);
      end
      count <= count + 4'(do_push) - 4'(do_pop);
    end
  end

endmodule

// [asc_sequencer_ctrl.sv]
// Sample sequencer control block with its APB registers.
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: Four sequencers with 8, 4, 4 and 1 steps and equal FIFO depths.
// RULE_02: Each FIFO word is 32 bits, result in the low ten bits.
// RULE_03: A step is an input-select nibble plus a control nibble.
// RULE_04: A sequencer runs only while its enable bit is set.
// RULE_05: A step with interrupt enable raises the raw interrupt when done.
// RULE_06: The sequence ends after the step marked end; later steps skipped.
// RULE_07: Reading the FIFO port returns and removes the oldest entry.
// RULE_08: Head, tail, full, empty readable; overflow and underflow flagged separately.
// RULE_09: Converter clock divided automatically to about 16.667 MHz.
// RULE_10: Raw interrupts always visible; only masked ones leave the block.
// RULE_11: Writing one to a masked status bit clears it; zero does nothing.
// RULE_12: Pending triggers served by priority value, zero highest.
// RULE_13: Software gives each enabled sequencer a distinct priority.
// RULE_14: Each sequencer selects processor, always or peripheral trigger.
// RULE_15: Initiate register bit starts a processor-triggered sequencer.
// RULE_16: Software should not give an always-triggered sequencer high priority.
// RULE_17: Averaging accumulates up to 64 conversions per FIFO entry.
// RULE_18: Averaging off after reset and shared by all channels.
// RULE_19: Single-ended codes run from 0x000 to 0x3FF.
// RULE_20: Differential pair k uses input 2k positive, 2k+1 negative.
// RULE_21: Differential zero difference gives 0x1FF, full range 0 to 0x3FF.
// RULE_22: Loopback test mode runs sequencers without the analog core.
// RULE_23: Full-FIFO result sets overflow, empty read sets underflow; write one clears.
module asc_sequencer_ctrl
  import asc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [N_PERIPH-1:0] PERIPH_TRIG,
  output logic CONV_CLK,
  output logic CONV_START,
  output logic [2:0] CONV_POS,
  output logic [2:0] CONV_NEG,
  output logic CONV_DIFF,
  output logic CONV_TEMP,
  input wire logic CONV_DONE,
  input wire logic [RES_W-1:0] CONV_DATA,
  output logic [NSEQ-1:0] SEQ_IRQ
);

  // Software-visible state.
  logic [NSEQ-1:0] enable;
  logic [NSEQ-1:0] raw_irq;
  logic [NSEQ-1:0] irq_mask;
  logic [NSEQ-1:0] overflow;
  logic [NSEQ-1:0] underflow;
  logic [15:0] trig_sel;
  logic [15:0] priority_val;
  logic [2:0] avg_log;
  logic loopback;
  logic [31:0] input_sel [0:NSEQ-1];
  logic [31:0] step_ctl [0:NSEQ-1];

  // Sequencing state.
  asc_state_t state;
  logic [NSEQ-1:0] pending;
  logic [1:0] cur_seq;
  logic [2:0] cur_step;
  logic [5:0] avg_cnt;
  logic [15:0] acc;
  logic [3:0] div_cnt;

  // Bus decode.
  logic wr_en;
  logic rd_acc;
  logic in_seq_win;
  logic [11:0] rel_addr;
  logic [1:0] win_seq;
  logic [4:0] win_reg;
  logic mapped;

  // FIFO wiring.
  logic [NSEQ-1:0] fifo_push;
  logic [NSEQ-1:0] fifo_pop;
  logic [NSEQ-1:0] fifo_full;
  logic [NSEQ-1:0] fifo_empty;
  logic [RES_W-1:0] fifo_head_data [0:NSEQ-1];
  logic [PTR_W-1:0] fifo_head [0:NSEQ-1];
  logic [PTR_W-1:0] fifo_tail [0:NSEQ-1];

  // Step decode and arbitration.
  logic [3:0] cur_sel;
  logic [3:0] cur_ctl;
  logic step_done;
  logic [RES_W-1:0] step_data;
  logic last_sample;
  logic [15:0] next_acc;
  logic [NSEQ-1:0] trig_fire;
  logic [NSEQ-1:0] eligible;
  logic grant_any;
  logic [1:0] grant_seq;
  logic [NSEQ-1:0] irq_set;

  function automatic logic [3:0] nibble(input logic [31:0] word, input logic [2:0] idx);
    nibble = word[{idx, 2'b00} +: 4];
  endfunction

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Zero-wait slave: read data is ready before the access phase.
  assign PREADY = 1'b1;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_acc = PSEL && PENABLE && !PWRITE;
  assign in_seq_win = (PADDR >= OFS_SEQ_BASE) && (PADDR < OFS_SEQ_END);
  assign rel_addr = PADDR - OFS_SEQ_BASE;
  assign win_seq = rel_addr[6:5];
  assign win_reg = rel_addr[4:0];

  always_comb
  begin
    case (PADDR)
      OFS_ACTIVATION, OFS_RAW_IRQ, OFS_IRQ_MASK, OFS_MASKED_CLR, OFS_OVERFLOW,
      OFS_TRIG_SEL, OFS_UNDERFLOW, OFS_PRIORITY, OFS_INITIATE, OFS_AVERAGING,
      OFS_LOOPBACK: mapped = 1'b1;
      default: mapped = in_seq_win && (win_reg == REL_INPUT_SEL || win_reg == REL_STEP_CTL ||
                                       win_reg == REL_FIFO_PORT || win_reg == REL_FIFO_STAT);
    endcase
  end

  // Unmapped addresses answer with an error and have no effect.
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // Read data is loaded in the setup cycle.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PRDATA <= 32'h00000000;
    end
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      PRDATA <= 32'h00000000;
      case (PADDR)
        OFS_ACTIVATION: PRDATA <= {28'h0, enable};
        OFS_RAW_IRQ: PRDATA <= {28'h0, raw_irq}; // RULE_10
        OFS_IRQ_MASK: PRDATA <= {28'h0, irq_mask};
        OFS_MASKED_CLR: PRDATA <= {28'h0, raw_irq & irq_mask}; // RULE_10
        OFS_OVERFLOW: PRDATA <= {28'h0, overflow}; // RULE_08
        OFS_TRIG_SEL: PRDATA <= {16'h0, trig_sel};
        OFS_UNDERFLOW: PRDATA <= {28'h0, underflow}; // RULE_08
        OFS_PRIORITY: PRDATA <= {16'h0, priority_val};
        OFS_AVERAGING: PRDATA <= {29'h0, avg_log};
        OFS_LOOPBACK: PRDATA <= {31'h0, loopback};
        default:
        begin
          if (in_seq_win)
          begin
            case (win_reg)
              REL_INPUT_SEL: PRDATA <= input_sel[win_seq];
              REL_STEP_CTL: PRDATA <= step_ctl[win_seq];
              REL_FIFO_PORT: PRDATA <= {22'h0, fifo_head_data[win_seq]}; // RULE_02 RULE_07
              REL_FIFO_STAT: PRDATA <= 32'(fifo_head[win_seq]) << STAT_HEAD_LSB
                | 32'(fifo_tail[win_seq]) << STAT_TAIL_LSB
                | 32'(fifo_empty[win_seq]) << STAT_EMPTY
                | 32'(fifo_full[win_seq]) << STAT_FULL; // RULE_08
              default: PRDATA <= 32'h00000000;
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Plain read/write registers.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      enable <= 4'h0;
      irq_mask <= 4'h0;
      trig_sel <= 16'h0000;
      priority_val <= PRIORITY_RESET;
      avg_log <= 3'h0; // RULE_18
      loopback <= 1'b0;
    end
    else if (wr_en)
    begin
      case (PADDR)
        OFS_ACTIVATION: enable <= PWDATA[3:0]; // RULE_04
        OFS_IRQ_MASK: irq_mask <= PWDATA[3:0];
        OFS_TRIG_SEL: trig_sel <= PWDATA[15:0]; // RULE_14
        OFS_PRIORITY: priority_val <= PWDATA[15:0] & 16'h3333; // RULE_12
        OFS_AVERAGING: avg_log <= (PWDATA[2:0] > AVG_MAX_LOG) ? AVG_MAX_LOG : PWDATA[2:0]; // RULE_17
        OFS_LOOPBACK: loopback <= PWDATA[0]; // RULE_22
        default: ;
      endcase
    end
  end

  // Step tables; sequencer three resets to one step marked last.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (int k = 0; k < NSEQ; k++)
      begin
        input_sel[k] <= 32'h00000000;
        step_ctl[k] <= (k == 3) ? CTL_SEQ3_RESET : 32'h00000000;
      end
    end
    else if (wr_en && in_seq_win)
    begin
      for (int k = 0; k < NSEQ; k++)
      begin
        // Nibbles past the step count stay zero.
        if (win_seq == 2'(k) && win_reg == REL_INPUT_SEL)
        begin
          input_sel[k] <= PWDATA & (32'hFFFFFFFF >> (32 - 4 * int'(asc_depth(k)))); // RULE_01 RULE_03
        end
        if (win_seq == 2'(k) && win_reg == REL_STEP_CTL)
        begin
          step_ctl[k] <= PWDATA & (32'hFFFFFFFF >> (32 - 4 * int'(asc_depth(k)))); // RULE_03
        end
      end
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // A hardware set beats a same-cycle clear.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      raw_irq <= 4'h0;
      overflow <= 4'h0;
      underflow <= 4'h0;
    end
    else
    begin
      raw_irq <= (raw_irq & ~((wr_en && PADDR == OFS_MASKED_CLR) ? PWDATA[3:0] : 4'h0)) | irq_set; // RULE_11
      overflow <= (overflow & ~((wr_en && PADDR == OFS_OVERFLOW) ? PWDATA[3:0] : 4'h0))
        | (fifo_push & fifo_full); // RULE_23
      underflow <= (underflow & ~((wr_en && PADDR == OFS_UNDERFLOW) ? PWDATA[3:0] : 4'h0))
        | (fifo_pop & fifo_empty); // RULE_23
    end
  end

  // Masked interrupts leave the block.
  assign SEQ_IRQ = raw_irq & irq_mask; // RULE_10

  // ----------------------------------------
  // Triggers and arbitration
  // ----------------------------------------
  // Per-sequencer trigger selection.
  always_comb
  begin
    for (int k = 0; k < NSEQ; k++)
    begin
      case (trig_sel[4 * k +: 4])
        TRIG_PROCESSOR: trig_fire[k] = wr_en && PADDR == OFS_INITIATE && PWDATA[k]; // RULE_15
        TRIG_ALWAYS: trig_fire[k] = 1'b1; // RULE_14
        4'h1, 4'h2, 4'h3, 4'h4: trig_fire[k] = PERIPH_TRIG[trig_sel[4 * k +: 2] - 2'h1]; // RULE_14
        default: trig_fire[k] = 1'b0;
      endcase
    end
  end

  // A trigger is remembered until its sequencer starts; disabling drops it.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pending <= 4'h0;
    end
    else
    begin
      for (int k = 0; k < NSEQ; k++)
      begin
        if (!enable[k])
        begin
          pending[k] <= 1'b0; // RULE_04
        end
        else if (trig_fire[k])
        begin
          pending[k] <= 1'b1;
        end
        else if (state == ST_IDLE && grant_any && grant_seq == 2'(k))
        begin
          pending[k] <= 1'b0;
        end
      end
    end
  end

  // Lowest priority value wins; a tie goes to the lower index.
  always_comb
  begin
    eligible = pending & enable;
    grant_any = 1'b0;
    grant_seq = 2'h0;
    for (int p = 3; p >= 0; p--)
    begin
      for (int k = NSEQ - 1; k >= 0; k--)
      begin
        if (eligible[k] && priority_val[4 * k +: 2] == 2'(p))
        begin
          grant_any = 1'b1; // RULE_12
          grant_seq = 2'(k);
        end
      end
    end
  end

  // ----------------------------------------
  // Step execution
  // ----------------------------------------
  assign cur_sel = nibble(input_sel[cur_seq], cur_step);
  assign cur_ctl = nibble(step_ctl[cur_seq], cur_step);
  // Loopback answers at once with a code built from the step.
  assign step_done = (state == ST_WAIT) && (loopback || CONV_DONE); // RULE_22
  assign step_data = loopback ? {cur_seq, cur_step, cur_sel, cur_ctl[CTL_DIFF]} : CONV_DATA; // RULE_19 RULE_21
  assign last_sample = (avg_cnt == 6'((7'h1 << avg_log) - 7'h1)); // RULE_17
  assign next_acc = acc + 16'(step_data);

  // The running sequencer feeds its FIFO; the bus pops on a read of the port.
  always_comb
  begin
    for (int k = 0; k < NSEQ; k++)
    begin
      fifo_push[k] = step_done && last_sample && cur_seq == 2'(k);
      fifo_pop[k] = rd_acc && in_seq_win && win_seq == 2'(k) && win_reg == REL_FIFO_PORT; // RULE_07
      irq_set[k] = fifo_push[k] && cur_ctl[CTL_IE]; // RULE_05
    end
  end

  // One conversion at a time.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= ST_IDLE;
      cur_seq <= 2'h0;
      cur_step <= 3'h0;
      avg_cnt <= 6'h0;
      acc <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (grant_any)
          begin
            cur_seq <= grant_seq;
            cur_step <= 3'h0;
            avg_cnt <= 6'h0;
            acc <= 16'h0000;
            state <= ST_START;
          end
        end
        ST_START:
        begin
          state <= enable[cur_seq] ? ST_WAIT : ST_IDLE; // RULE_04
        end
        ST_WAIT:
        begin
          if (!enable[cur_seq])
          begin
            state <= ST_IDLE; // RULE_04
          end
          else if (step_done && !last_sample)
          begin
            acc <= next_acc; // RULE_17
            avg_cnt <= avg_cnt + 6'h1;
            state <= ST_START;
          end
          else if (step_done)
          begin
            acc <= 16'h0000;
            avg_cnt <= 6'h0;
            if (cur_ctl[CTL_END] || 4'({1'b0, cur_step}) == asc_depth(int'(cur_seq)) - 4'h1)
            begin
              state <= ST_IDLE; // RULE_06
            end
            else
            begin
              cur_step <= cur_step + 3'h1;
              state <= ST_START;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Converter command outputs; no start pulse in loopback.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CONV_START <= 1'b0;
      CONV_POS <= 3'h0;
      CONV_NEG <= 3'h0;
      CONV_DIFF <= 1'b0;
      CONV_TEMP <= 1'b0;
    end
    else
    begin
      CONV_START <= (state == ST_START) && enable[cur_seq] && !loopback;
      CONV_DIFF <= cur_ctl[CTL_DIFF];
      CONV_TEMP <= cur_ctl[CTL_TEMP];
      if (cur_ctl[CTL_DIFF])
      begin
        CONV_POS <= {cur_sel[1:0], 1'b0}; // RULE_20
        CONV_NEG <= {cur_sel[1:0], 1'b1}; // RULE_20
      end
      else
      begin
        CONV_POS <= cur_sel[2:0];
        CONV_NEG <= 3'h0;
      end
    end
  end

  // Converter clock; the ratio is fixed at build time.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      div_cnt <= 4'h0;
      CONV_CLK <= 1'b0;
    end
    else if (div_cnt == CONV_HALF - 4'h1)
    begin
      div_cnt <= 4'h0;
      CONV_CLK <= ~CONV_CLK; // RULE_09
    end
    else
    begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // ----------------------------------------
  // Result FIFOs
  // ----------------------------------------
  // Average is the sum shifted down by the exponent.
  for (genvar k = 0; k < NSEQ; k++)
  begin : g_fifo
    asc_result_fifo #(
      .DEPTH(asc_depth(k))
    ) u_fifo (
      .clk(CLK),
      .rst_n(RST_N),
      .push(fifo_push[k]),
      .push_data(10'(next_acc >> avg_log)), // RULE_17
      .pop(fifo_pop[k]),
      .head_data(fifo_head_data[k]),
      .head(fifo_head[k]),
      .tail(fifo_tail[k]),
      .full(fifo_full[k]),
      .empty(fifo_empty[k])
    ); // RULE_01
  end

endmodule

// [asc_monitor.sv]
// Port-level checks for the sequencer control block.
`timescale 1ns/1ps
module asc_monitor
  import asc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  input wire logic CONV_CLK,
  input wire logic CONV_START,
  input wire logic [2:0] CONV_POS,
  input wire logic [2:0] CONV_NEG,
  input wire logic CONV_DIFF,
  input wire logic CONV_DONE,
  input wire logic [NSEQ-1:0] SEQ_IRQ
);
  logic acc;
  logic [3:0] wbits;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Completed write and its low data bits.
  assign acc = PSEL && PENABLE && PWRITE;
  assign wbits = PWDATA[3:0];
  // Converter clock toggles every third system cycle.
  chk_conv_clk_period: assert property ($changed(CONV_CLK) |=> $stable(CONV_CLK)[*2] ##1 $changed(CONV_CLK))
    else $error("converter clock period wrong");
  chk_start_single_pulse: assert property (CONV_START |=> !CONV_START && $stable(CONV_POS) && $stable(CONV_DIFF))
    else $error("start pulse or step fields unstable");
  chk_diff_pair_map: assert property (CONV_START && CONV_DIFF |-> !CONV_POS[0] && CONV_NEG == CONV_POS + 3'h1)
    else $error("differential pair mapping wrong");
  chk_single_neg_zero: assert property (CONV_START && !CONV_DIFF |-> CONV_NEG == 3'h0)
    else $error("single-ended negative input not zero");
  chk_done_start_gap: assert property (CONV_DONE |=> !CONV_START)
    else $error("start too soon after done");
  // A set in the same cycle wins, so only quiet cycles are judged.
  chk_irq_clear_write: assert property (acc && PADDR == OFS_MASKED_CLR && !CONV_DONE |=> (SEQ_IRQ & $past(wbits)) == 4'h0)
    else $error("interrupt not cleared");
  chk_irq_mask_gate: assert property (acc && PADDR == OFS_IRQ_MASK |=> (SEQ_IRQ & ~$past(wbits)) == 4'h0)
    else $error("masked interrupt leaked");
  chk_disable_quiet: assert property (acc && PADDR == OFS_ACTIVATION && wbits == 4'h0 |=> ##1 !CONV_START[*4])
    else $error("conversion started while disabled");
endmodule

// [asc_core_model.sv]
// Behavioural analog converter core answering conversion requests.
`timescale 1ns/1ps
module asc_core_model
  import asc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [2:0] pos,
  input wire logic [2:0] neg,
  input wire logic diff,
  input wire logic [3:0] lat,
  output logic done,
  output logic [RES_W-1:0] data
);
  logic busy;
  logic [3:0] cnt;
  logic [RES_W-1:0] held;
  logic signed [11:0] delta;
  function automatic logic [RES_W-1:0] level(input logic [2:0] ch);
    level = (ch == 3'h7) ? 10'h3FF : 10'(ch) * 10'h050;
  endfunction
  // Differential codes are centred on mid-scale.
  assign delta = $signed({2'b00, level(pos)}) - $signed({2'b00, level(neg)});
  // Data is scrambled outside done so a stale value cannot pass.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      cnt <= 4'h0;
      done <= 1'b0;
      data <= 10'h000;
      held <= 10'h000;
    end
    else
    begin
      done <= 1'b0;
      data <= ~data;
      if (start)
      begin
        busy <= 1'b1;
        cnt <= lat;
        held <= diff ? 10'($signed(12'h1FF) + (delta >>> 1)) : level(pos);
      end
      else if (busy && cnt == 4'h0)
      begin
        busy <= 1'b0;
        done <= 1'b1;
        data <= held;
      end
      else if (busy)
        cnt <= cnt - 4'h1;
    end
  end
endmodule

// [asc_sequencer_ctrl_bench.sv]
// Self-checking bench for the sequencer control block.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module asc_sequencer_ctrl_bench
  import asc_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] trig, irq, lat;
  logic cclk, cstart, cdiff, ctemp, cdone;
  logic [2:0] cpos, cneg;
  logic [9:0] cdata;
  int fail_count, checked;
  logic [2:0] pos_q[$];
  asc_sequencer_ctrl DUT (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PERIPH_TRIG(trig), .CONV_CLK(cclk), .CONV_START(cstart), .CONV_POS(cpos), .CONV_NEG(cneg),
    .CONV_DIFF(cdiff), .CONV_TEMP(ctemp), .CONV_DONE(cdone), .CONV_DATA(cdata), .SEQ_IRQ(irq));
  asc_core_model core (.clk(clk), .rst_n(rst_n), .start(cstart), .pos(cpos), .neg(cneg),
    .diff(cdiff), .lat(lat), .done(cdone), .data(cdata));
  // Conversion requests are logged for count and order checks.
  always @(posedge clk)
    if (cstart)
      pos_q.push_back(cpos);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [11:0] sa(input int k, input logic [4:0] r);
    sa = OFS_SEQ_BASE + 12'(k * 32) + {7'h00, r};
  endfunction
  // One APB transfer, held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e);
  endtask
  // Bounded poll until all bits of m are set.
  task automatic wait_set(input logic [11:0] a, input logic [3:0] m);
    int i;
    rd = 32'h0;
    for (i = 0; i < 100 && (rd[3:0] & m) !== m; i++)
      apb(1'b0, a, 32'h0);
    if (i >= 100)
    begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic t_reset();
    rc(OFS_ACTIVATION, 32'h0);
    rc(OFS_PRIORITY, 32'h3210);
    rc(OFS_AVERAGING, 32'h0);
    rc(sa(3, REL_STEP_CTL), 32'h2);
    rc(sa(0, REL_FIFO_STAT), 32'h100);
    apb(1'b0, 12'h01C, 32'h0);
    `CHK(err, 1'b1);
    $display("reset test done");
  endtask
  // END sits on the fifth of eight steps.
  task automatic t_sequence();
    logic [31:0] codes[5] = '{32'h000, 32'h3FF, 32'h1D7, 32'h0EF, 32'h3FF};
    lat <= 4'h3;
    wr(sa(0, REL_INPUT_SEL), 32'h00173070);
    wr(sa(0, REL_STEP_CTL), 32'h00061100);
    wr(OFS_ACTIVATION, 32'h1);
    pos_q.delete();
    wr(OFS_INITIATE, 32'h1);
    wait_set(OFS_RAW_IRQ, 4'h1);
    `CHK(pos_q.size(), 5);
    `CHK(irq, 4'h0);
    foreach (codes[i])
      rc(sa(0, REL_FIFO_PORT), codes[i]);
    rc(sa(0, REL_FIFO_STAT), 32'h155);
    apb(1'b0, sa(0, REL_FIFO_PORT), 32'h0);
    rc(OFS_UNDERFLOW, 32'h1);
    wr(OFS_UNDERFLOW, 32'h1);
    rc(OFS_UNDERFLOW, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    @(negedge clk);
    `CHK(irq, 4'h1);
    wr(OFS_MASKED_CLR, 32'h0);
    rc(OFS_MASKED_CLR, 32'h1);
    wr(OFS_MASKED_CLR, 32'h1);
    rc(OFS_RAW_IRQ, 32'h0);
    wr(OFS_ACTIVATION, 32'h0);
    $display("sequence test done");
  endtask
  // Two started at once: priority decides, then a one-entry overflow.
  task automatic t_priority();
    lat <= 4'h0;
    wr(OFS_PRIORITY, 32'h0231);
    wr(sa(3, REL_INPUT_SEL), 32'h5);
    wr(sa(3, REL_STEP_CTL), 32'h6);
    wr(sa(1, REL_INPUT_SEL), 32'h2);
    wr(sa(1, REL_STEP_CTL), 32'h6);
    wr(OFS_ACTIVATION, 32'hA);
    pos_q.delete();
    wr(OFS_INITIATE, 32'hA);
    wait_set(OFS_RAW_IRQ, 4'hA);
    `CHK(pos_q[0], 3'h5);
    rc(sa(1, REL_FIFO_PORT), 32'h0A0);
    wr(OFS_MASKED_CLR, 32'hF);
    wr(OFS_INITIATE, 32'h8);
    wait_set(OFS_OVERFLOW, 4'h8);
    apb(1'b0, sa(3, REL_FIFO_STAT), 32'h0);
    `CHK(rd & 32'h1100, 32'h1000);
    rc(sa(3, REL_FIFO_PORT), 32'h190);
    wr(OFS_OVERFLOW, 32'h8);
    rc(OFS_OVERFLOW, 32'h0);
    $display("priority test done");
  endtask
  task automatic t_average();
    lat <= 4'h1;
    wr(OFS_AVERAGING, 32'h2);
    wr(OFS_TRIG_SEL, 32'h100);
    wr(sa(2, REL_INPUT_SEL), 32'h4);
    wr(sa(2, REL_STEP_CTL), 32'h6);
    wr(OFS_ACTIVATION, 32'h4);
    pos_q.delete();
    @(posedge clk) trig <= 4'h1;
    @(posedge clk) trig <= 4'h0;
    wait_set(OFS_RAW_IRQ, 4'h4);
    `CHK(pos_q.size(), 4);
    rc(sa(2, REL_FIFO_PORT), 32'h140);
    wr(OFS_AVERAGING, 32'h0);
    wr(OFS_LOOPBACK, 32'h1);
    wr(OFS_ACTIVATION, 32'h2);
    wr(OFS_MASKED_CLR, 32'hF);
    pos_q.delete();
    wr(OFS_TRIG_SEL, 32'hF0);
    wait_set(OFS_RAW_IRQ, 4'h2);
    `CHK(pos_q.size(), 0);
    rc(sa(1, REL_FIFO_PORT), 32'h104);
    $display("average and loopback test done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, trig, lat} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_sequence();
    t_priority();
    t_average();
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule
bind asc_sequencer_ctrl asc_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .CONV_CLK(CONV_CLK), .CONV_START(CONV_START),
  .CONV_POS(CONV_POS), .CONV_NEG(CONV_NEG), .CONV_DIFF(CONV_DIFF), .CONV_DONE(CONV_DONE), .SEQ_IRQ(SEQ_IRQ));
